// [hdl/bllc_regs.sv]
`timescale 1ns/100ps
// Summary of operation
// - daylight dims to daylight dim code
// - office max register at 0x0B
// - office dim register at 0x0C
// - office dims to office dim code
// - dark max register at 0x0D
// - code maps by linear or square law
// - daylight dim register at 0x0A
module bllc_regs (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic [1:0]  level,
  input  wire logic        dim_en,
  input  wire logic        dim_timeout,
  input  wire logic        wake,
  input  wire logic        square_law,
  input  wire logic [6:0]  daylight_max_code,
  input  wire logic [6:0]  dark_dim_code,
  output logic      [6:0]  sink_code,
  output logic             dimmed,
  output logic      [15:0] sink_current_ua
);
  logic [6:0]              daylight_dim_code_reg;
  logic [6:0]              office_max_code_reg;
  logic [6:0]              office_dim_code_reg;
  logic [6:0]              dark_max_code_reg;
  logic [7:0]              rdata_reg;
  logic [7:0]              rdata_next;
  logic [6:0]              sink_code_reg;
  logic [6:0]              sink_code_next;
  bllc_pkg::bllc_state_t   state_reg;
  bllc_pkg::bllc_state_t   state_next;
  logic                    dim_now;
  logic                    wr_go;

  bllc_dac_if dac_bus ();

  assign wr_go = ce && reg_wr;

  // one process per register; bit 7 of the write data is dropped
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      daylight_dim_code_reg <= bllc_pkg::CODE_RESET;
    else if (wr_go && reg_addr == bllc_pkg::ADDR_DAYLIGHT_DIM)
      daylight_dim_code_reg <= reg_wdata[bllc_pkg::CODE_MSB:0];
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      office_max_code_reg <= bllc_pkg::CODE_RESET;
    else if (wr_go && reg_addr == bllc_pkg::ADDR_OFFICE_MAX)
      office_max_code_reg <= reg_wdata[bllc_pkg::CODE_MSB:0];
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      office_dim_code_reg <= bllc_pkg::CODE_RESET;
    else if (wr_go && reg_addr == bllc_pkg::ADDR_OFFICE_DIM)
      office_dim_code_reg <= reg_wdata[bllc_pkg::CODE_MSB:0];
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      dark_max_code_reg <= bllc_pkg::CODE_RESET;
    else if (wr_go && reg_addr == bllc_pkg::ADDR_DARK_MAX)
      dark_max_code_reg <= reg_wdata[bllc_pkg::CODE_MSB:0];
  end

  // read mux; unmapped addresses and the reserved bit read as zero
  always_comb
  begin
    case (reg_addr)
      bllc_pkg::ADDR_DAYLIGHT_DIM:
        rdata_next = {bllc_pkg::RSVD_BIT_VAL, daylight_dim_code_reg};
      bllc_pkg::ADDR_OFFICE_MAX:
        rdata_next = {bllc_pkg::RSVD_BIT_VAL, office_max_code_reg};
      bllc_pkg::ADDR_OFFICE_DIM:
        rdata_next = {bllc_pkg::RSVD_BIT_VAL, office_dim_code_reg};
      bllc_pkg::ADDR_DARK_MAX:
        rdata_next = {bllc_pkg::RSVD_BIT_VAL, dark_max_code_reg};
      default:
        rdata_next = bllc_pkg::RDATA_NONE;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_reg <= bllc_pkg::RDATA_NONE;
    else if (ce && reg_rd)
      rdata_reg <= rdata_next;
  end

  // dim latch; a timeout in the same cycle as a wake wins, so it is not lost
  always_comb
  begin
    case (state_reg)
      bllc_pkg::BLLC_ST_BRIGHT:
        state_next = dim_timeout ? bllc_pkg::BLLC_ST_DIM : bllc_pkg::BLLC_ST_BRIGHT;
      bllc_pkg::BLLC_ST_DIM:
        state_next = (wake && !dim_timeout) ? bllc_pkg::BLLC_ST_BRIGHT : bllc_pkg::BLLC_ST_DIM;
      default:
        state_next = bllc_pkg::BLLC_ST_BRIGHT;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state_reg <= bllc_pkg::BLLC_ST_BRIGHT;
    else if (ce)
      state_reg <= state_next;
  end

  // software flag forces dim regardless of the timer
  assign dim_now = dim_en || (state_reg == bllc_pkg::BLLC_ST_DIM);

  // code for the active ambient level
  always_comb
  begin
    case (level)
      bllc_pkg::BLLC_LVL_DAYLIGHT:
        sink_code_next = dim_now ? daylight_dim_code_reg : daylight_max_code;
      bllc_pkg::BLLC_LVL_OFFICE:
        sink_code_next = dim_now ? office_dim_code_reg : office_max_code_reg;
      bllc_pkg::BLLC_LVL_DARK:
        sink_code_next = dim_now ? dark_dim_code : dark_max_code_reg;
      default:
        sink_code_next = bllc_pkg::CODE_RESET; // unused level code keeps sink off
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sink_code_reg <= bllc_pkg::CODE_RESET;
    else if (ce)
      sink_code_reg <= sink_code_next;
  end

  // law and scale live in the mapper, one cycle behind the code
  assign dac_bus.code       = sink_code_reg;
  assign dac_bus.square_law = square_law;

  bllc_dac_map u_map (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .dac  (dac_bus.map)
  );

  assign reg_rdata       = rdata_reg;
  assign sink_code       = sink_code_reg;
  assign dimmed          = dim_now;
  assign sink_current_ua = dac_bus.current_ua;

  AST_DAYLIGHT_DIM: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && level == bllc_pkg::BLLC_LVL_DAYLIGHT && dim_now)
      |=> sink_code_reg == $past(daylight_dim_code_reg))
    else $error("daylight dim code not applied");
  AST_OFFICE_MAX_WR: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && reg_wr && reg_addr == bllc_pkg::ADDR_OFFICE_MAX)
      |=> office_max_code_reg == $past(reg_wdata[bllc_pkg::CODE_MSB:0]))
    else $error("office max write lost");
  AST_OFFICE_DIM_WR: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && reg_wr && reg_addr == bllc_pkg::ADDR_OFFICE_DIM)
      ##1 (ce && reg_rd && reg_addr == bllc_pkg::ADDR_OFFICE_DIM)
      |=> reg_rdata == {bllc_pkg::RSVD_BIT_VAL, $past(reg_wdata[bllc_pkg::CODE_MSB:0], 2)})
    else $error("office dim readback wrong");
  // state turns dim one edge after the timeout, the code follows one edge later
  AST_OFFICE_DIM_SEL: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && level == bllc_pkg::BLLC_LVL_OFFICE && dim_timeout)
      ##1 (ce && level == bllc_pkg::BLLC_LVL_OFFICE)
      |=> sink_code_reg == $past(office_dim_code_reg))
    else $error("office dim after timeout missing");
  AST_DARK_MAX_WR: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && reg_wr && reg_addr == bllc_pkg::ADDR_DARK_MAX)
      |=> dark_max_code_reg == $past(reg_wdata[bllc_pkg::CODE_MSB:0]))
    else $error("dark max write lost");
  AST_DAYLIGHT_WR: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && reg_wr && reg_addr == bllc_pkg::ADDR_DAYLIGHT_DIM)
      |=> daylight_dim_code_reg == $past(reg_wdata[bllc_pkg::CODE_MSB:0]))
    else $error("daylight dim write lost");
  AST_RSVD_ZERO: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && reg_rd) |=> !reg_rdata[7])
    else $error("reserved bit read nonzero");
  AST_FREEZE: assert property (
    @(posedge clk) disable iff (!nrst)
    !ce |=> $stable(sink_code_reg) && $stable(rdata_reg))
    else $error("state moved while disabled");
  COV_DAY_DIM: cover property (
    @(posedge clk) disable iff (!nrst)
    level == bllc_pkg::BLLC_LVL_DAYLIGHT && dim_timeout ##1 state_reg == bllc_pkg::BLLC_ST_DIM);
  COV_OFFICE_FLAG: cover property (
    @(posedge clk) disable iff (!nrst)
    level == bllc_pkg::BLLC_LVL_OFFICE && dim_en);
  COV_WAKE: cover property (
    @(posedge clk) disable iff (!nrst)
    state_reg == bllc_pkg::BLLC_ST_DIM ##1 state_reg == bllc_pkg::BLLC_ST_BRIGHT);
endmodule : bllc_regs

// [include/bllc_pkg.sv]
package bllc_pkg;
  // register map, one byte each on the internal host register port
  localparam logic [7:0] ADDR_DAYLIGHT_DIM = 8'h0A;
  localparam logic [7:0] ADDR_OFFICE_MAX   = 8'h0B;
  localparam logic [7:0] ADDR_OFFICE_DIM   = 8'h0C;
  localparam logic [7:0] ADDR_DARK_MAX     = 8'h0D;
  localparam int         CODE_W            = 7;
  localparam int         CODE_MSB          = 6;
  localparam logic [6:0] CODE_RESET        = 7'h00;
  localparam logic [6:0] CODE_FULL         = 7'h7F;
  localparam logic [7:0] RDATA_NONE        = 8'h00;
  localparam logic       RSVD_BIT_VAL      = 1'b0;
  // current scale in microamps, full scale 30 mA at the all-ones code
  localparam int         CURR_W            = 16;
  localparam int         FULL_SCALE_UA     = 30000;
  localparam int         CODE_SPAN         = 127;
  localparam int         CODE_SPAN_SQ      = 16129;
  localparam int         STEP_UA           = 236;
  localparam int         SQ_CODE1_UA       = 2;
  typedef enum logic [1:0] {
    BLLC_LVL_DAYLIGHT = 2'h0,
    BLLC_LVL_OFFICE   = 2'h1,
    BLLC_LVL_DARK     = 2'h3
  } bllc_level_t;
  typedef enum logic {
    BLLC_ST_BRIGHT = 1'b0,
    BLLC_ST_DIM    = 1'b1
  } bllc_state_t;
endpackage : bllc_pkg

// [include/bllc_dac_if.sv]
`timescale 1ns/100ps
interface bllc_dac_if;
  logic [6:0]  code;
  logic        square_law;
  logic [15:0] current_ua;
  modport src (output code, output square_law, input current_ua);
  modport map (input code, input square_law, output current_ua);
endinterface : bllc_dac_if

// [hdl/bllc_dac_map.sv]
`timescale 1ns/100ps
module bllc_dac_map (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  bllc_dac_if.map   dac
);
  logic [31:0] lin_num;
  logic [31:0] sq_num;
  logic [31:0] ua_next;
  logic [15:0] current_reg;

  // rounded integer law, so the all-ones code lands exactly on full scale
  always_comb
  begin
    lin_num = 32'(dac.code) * 32'(bllc_pkg::FULL_SCALE_UA) + 32'(bllc_pkg::CODE_SPAN / 2);
    sq_num  = 32'(dac.code) * 32'(dac.code) * 32'(bllc_pkg::FULL_SCALE_UA)
            + 32'(bllc_pkg::CODE_SPAN_SQ / 2);
    if (dac.square_law)
      ua_next = sq_num / 32'(bllc_pkg::CODE_SPAN_SQ);
    else
      ua_next = lin_num / 32'(bllc_pkg::CODE_SPAN);
  end

  // registered so the sink sees a glitch-free value
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      current_reg <= 16'h0000;
    else if (ce)
      current_reg <= ua_next[15:0];
  end

  assign dac.current_ua = current_reg;

  AST_LINEAR_STEP: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && !dac.square_law && dac.code == 7'h01) |=> current_reg == 16'(bllc_pkg::STEP_UA))
    else $error("linear code one not one step");
  AST_SQUARE_FIRST: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && dac.square_law && dac.code == 7'h01) |=> current_reg == 16'(bllc_pkg::SQ_CODE1_UA))
    else $error("square code one wrong");
  AST_FULL_SCALE: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && dac.code == bllc_pkg::CODE_FULL) |=> current_reg == 16'(bllc_pkg::FULL_SCALE_UA))
    else $error("all-ones code not full scale");
  COV_FULL_SQUARE: cover property (
    @(posedge clk) disable iff (!nrst)
    ce && dac.square_law && dac.code == bllc_pkg::CODE_FULL);
endmodule : bllc_dac_map

// [testbench/bllc_regs_tb.sv]
`timescale 1ns/100ps
module bllc_regs_tb;
  logic        clk;
  logic        nrst;
  logic        ce;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [1:0]  level;
  logic        dim_en;
  logic        dim_timeout;
  logic        wake;
  logic        square_law;
  logic [6:0]  daylight_max_code;
  logic [6:0]  dark_dim_code;
  logic [6:0]  sink_code;
  logic        dimmed;
  logic [15:0] sink_current_ua;
  int          error_cnt;
  int          n_checks;
  int          cyc;

  bllc_regs i_dut (
    .clk               (clk),
    .nrst              (nrst),
    .ce                (ce),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_rdata         (reg_rdata),
    .level             (level),
    .dim_en            (dim_en),
    .dim_timeout       (dim_timeout),
    .wake              (wake),
    .square_law        (square_law),
    .daylight_max_code (daylight_max_code),
    .dark_dim_code     (dark_dim_code),
    .sink_code         (sink_code),
    .dimmed            (dimmed),
    .sink_current_ua   (sink_current_ua)
  );

  // 100 MHz clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic print_verdict;
    $display("checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [15:0] act, input logic [15:0] exp);
    n_checks++;
    if (act !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, act, exp);
    end
  endtask : check

  // strobe held exactly one taken edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data is registered, so look one edge after the taken one
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    #1;
    check({8'h00, reg_rdata}, {8'h00, exp});
  endtask : rd

  // code lands after one edge, current after two; three gives margin
  task automatic sel(input logic [6:0] code, input logic [15:0] ua, input logic dm);
    repeat (3) @(posedge clk);
    #1;
    check({9'h000, sink_code}, {9'h000, code});
    check(sink_current_ua, ua);
    check({15'h0000, dimmed}, {15'h0000, dm});
  endtask : sel

  // hang guard, far above the roughly one hundred cycles the run needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  initial
  begin
    nrst              = 1'b0;
    ce                = 1'b1;
    reg_wr            = 1'b0;
    reg_rd            = 1'b0;
    reg_addr          = 8'h00;
    reg_wdata         = 8'h00;
    level             = 2'h0;
    dim_en            = 1'b0;
    dim_timeout       = 1'b0;
    wake              = 1'b0;
    square_law        = 1'b0;
    daylight_max_code = 7'h11;
    dark_dim_code     = 7'h22;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(bllc_pkg::ADDR_DAYLIGHT_DIM, 8'h00);
    rd(bllc_pkg::ADDR_OFFICE_MAX, 8'h00);
    rd(bllc_pkg::ADDR_OFFICE_DIM, 8'h00);
    rd(bllc_pkg::ADDR_DARK_MAX, 8'h00);
    // bit 7 set in every write must be dropped
    wr(bllc_pkg::ADDR_DAYLIGHT_DIM, 8'h81);
    wr(bllc_pkg::ADDR_OFFICE_MAX, 8'h82);
    wr(bllc_pkg::ADDR_OFFICE_DIM, 8'h85);
    wr(bllc_pkg::ADDR_DARK_MAX, 8'hFF);
    rd(bllc_pkg::ADDR_DAYLIGHT_DIM, 8'h01);
    rd(bllc_pkg::ADDR_OFFICE_MAX, 8'h02);
    rd(bllc_pkg::ADDR_OFFICE_DIM, 8'h05);
    rd(bllc_pkg::ADDR_DARK_MAX, 8'h7F);
    // write then read on the very next edge must return the new value
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= bllc_pkg::ADDR_OFFICE_DIM;
    reg_wdata <= 8'hC6;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check({8'h00, reg_rdata}, 16'h0046);
    // unmapped place and a write with the clock enable low
    wr(8'h0E, 8'h55);
    rd(8'h0E, 8'h00);
    @(posedge clk);
    ce <= 1'b0;
    wr(bllc_pkg::ADDR_OFFICE_MAX, 8'h33);
    @(posedge clk);
    ce <= 1'b1;
    rd(bllc_pkg::ADDR_OFFICE_MAX, 8'h02);
    // office bright then software dim; 2 -> 472 uA, 0x46 -> 16535 uA
    @(posedge clk);
    level <= 2'h1;
    sel(7'h02, 16'h01D8, 1'b0);
    @(posedge clk);
    dim_en <= 1'b1;
    sel(7'h46, 16'h4097, 1'b1);
    // office timer dim, then timeout and wake together: dim must stay
    @(posedge clk);
    dim_en      <= 1'b0;
    dim_timeout <= 1'b1;
    @(posedge clk);
    dim_timeout <= 1'b0;
    sel(7'h46, 16'h4097, 1'b1);
    @(posedge clk);
    dim_timeout <= 1'b1;
    wake        <= 1'b1;
    @(posedge clk);
    dim_timeout <= 1'b0;
    wake        <= 1'b0;
    sel(7'h46, 16'h4097, 1'b1);
    // a lone wake brings the office max code back
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    sel(7'h02, 16'h01D8, 1'b0);
    // daylight, timeout and wake together: timeout wins
    @(posedge clk);
    dim_en      <= 1'b0;
    level       <= 2'h0;
    dim_timeout <= 1'b1;
    wake        <= 1'b1;
    @(posedge clk);
    dim_timeout <= 1'b0;
    wake        <= 1'b0;
    sel(7'h01, 16'h00EC, 1'b1);
    @(posedge clk);
    square_law <= 1'b1;
    sel(7'h01, 16'h0002, 1'b1);
    // wake back to bright at full scale
    @(posedge clk);
    daylight_max_code <= 7'h7F;
    wake              <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    sel(7'h7F, 16'h7530, 1'b0);
    @(posedge clk);
    level      <= 2'h3;
    square_law <= 1'b0;
    sel(7'h7F, 16'h7530, 1'b0);
    @(posedge clk);
    level <= 2'h2;
    sel(7'h00, 16'h0000, 1'b0);
    print_verdict();
  end
endmodule : bllc_regs_tb
